// ### hw/rtcyac_cfg.svh
/*
  Constants of the year counter and alarm compare block: register byte offsets,
  field widths and masks, counting limits and interrupt bit positions.
  Assumes it is included by its bare name after the package.
*/
`ifndef RTCYAC_CFG_SVH
`define RTCYAC_CFG_SVH

// Register byte offsets on the APB port
`define RTCYAC_OFF_YEAR 8'h20
`define RTCYAC_OFF_AMIN 8'h24
`define RTCYAC_OFF_AHOUR 8'h28
`define RTCYAC_OFF_ADAY 8'h2C
`define RTCYAC_OFF_AMON 8'h30
`define RTCYAC_OFF_AYEAR 8'h34
`define RTCYAC_OFF_STATUS 8'h38
`define RTCYAC_OFF_MASK 8'h3C

// Store entry indices, offset minus year offset, over four
`define RTCYAC_IDX_YEAR 3'h0
`define RTCYAC_IDX_AMIN 3'h1
`define RTCYAC_IDX_AHOUR 3'h2
`define RTCYAC_IDX_ADAY 3'h3
`define RTCYAC_IDX_AMON 3'h4
`define RTCYAC_IDX_AYEAR 3'h5
`define RTCYAC_ENTRIES 6

// Writable field of each entry, reserved bits above read as zero
`define RTCYAC_MASK_YEAR 8'h7F
`define RTCYAC_MASK_AMIN 8'h3F
`define RTCYAC_MASK_AHOUR 8'h1F
`define RTCYAC_MASK_ADAY 8'h1F
`define RTCYAC_MASK_AMON 8'h0F
`define RTCYAC_MASK_AYEAR 8'h7F

// Year counting range
`define RTCYAC_YEAR_FIRST 7'h01
`define RTCYAC_YEAR_LAST 7'h63

// Interrupt status and mask layout
`define RTCYAC_EV_ALARM 0
`define RTCYAC_EV_WRAP 1
`define RTCYAC_EV_BITS 2
`define RTCYAC_STATUS_RESET 2'h0
`define RTCYAC_MASK_RESET 2'h0

`endif

// ### hw/rtcyac_pkg.sv
/*
  Types of the year counter and alarm compare block.
  Assumes nothing of its surroundings.
*/
package rtcyac_pkg;

  // Current time of the lower counters, outside this block
  typedef struct packed {
    logic [5:0] minute;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] month;
  } rtcyac_time_type;

  // One APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtcyac_apb_type;

  // APB answer phase
  typedef enum logic [0:0] {
    RTCYAC_IDLE,
    RTCYAC_ANSWER
  } rtcyac_phase_type;

endpackage : rtcyac_pkg

// ### hw/rtcyac_store.sv
/*
  Six-entry register store for the year counter and alarm compare values.
  Entries carry no reset, so their contents are unknown until written.
  Assumes one write port driven by the owner and a registered read port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcyac_cfg.svh"

module rtcyac_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [`RTCYAC_ENTRIES-1:0][7:0] entries
);

  localparam logic [7:0] FIELD_MASK [`RTCYAC_ENTRIES] = '{
    `RTCYAC_MASK_YEAR, `RTCYAC_MASK_AMIN, `RTCYAC_MASK_AHOUR,
    `RTCYAC_MASK_ADAY, `RTCYAC_MASK_AMON, `RTCYAC_MASK_AYEAR
  };

  // One entry per word, written value kept as is within its field
  for (genvar i = 0; i < `RTCYAC_ENTRIES; i++) begin : g_entry
    logic [7:0] next_word;
    always_comb begin
      next_word = entries[i];
      if (clk_en && wr_en && (wr_idx == 3'(i))) begin
        next_word = wr_data & FIELD_MASK[i];
      end
    end
    always_ff @(posedge pclk) begin
      entries[i] <= next_word;
    end
  end

  // Registered read port
  logic [7:0] next_rd_data;
  always_comb begin
    next_rd_data = rd_data;
    if (clk_en) begin
      next_rd_data = (rd_idx < 3'(`RTCYAC_ENTRIES)) ? entries[rd_idx] : 8'h00;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule : rtcyac_store
`default_nettype wire

// ### hw/rtcyac_top.sv
/*
  Year counter and alarm compare block with APB register port and alarm
  interrupt. Assumes the lower time counters feed cur_time and a one-cycle
  month_carry pulse, all synchronous to pclk, and an APB master on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcyac_cfg.svh"

// Function
// - Year counter holds seven-bit year, nominally 01 to 99, any write kept
// - Alarm minute holds six bits, values above 59 kept as written
// - Alarm hour holds five bits, values above 23 kept as written
// - Alarm day holds five bits, zero kept as written, bits above the field dropped
// - Alarm month holds four bits, zero or values above 12 kept
// - Alarm year holds seven bits, zero or values above 99 kept
// - Year and alarm registers are not cleared by system reset
// - Alarm flag reads one while pending; writing one clears, zero no effect
module rtcyac_top
  import rtcyac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rtcyac_time_type cur_time,
  input wire logic month_carry,
  output logic [6:0] year_value,
  output logic alarm_pending_flag,
  output logic irq
);

  rtcyac_apb_type req;
  rtcyac_phase_type phase;
  rtcyac_phase_type next_phase;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [`RTCYAC_EV_BITS-1:0] status;
  logic [`RTCYAC_EV_BITS-1:0] next_status;
  logic [`RTCYAC_EV_BITS-1:0] mask;
  logic [`RTCYAC_EV_BITS-1:0] next_mask;
  logic [`RTCYAC_EV_BITS-1:0] events;
  logic next_irq;
  logic match_q;
  logic next_match_q;
  logic match_now;
  logic [6:0] next_year_value;
  logic next_alarm_flag;
  logic commit;
  logic commit_wr;
  logic hit_store;
  logic hit_status;
  logic hit_mask;
  logic [2:0] idx;
  logic [6:0] year_cur;
  logic [6:0] year_inc;
  logic st_wr_en;
  logic [2:0] st_wr_idx;
  logic [7:0] st_wr_data;
  logic [7:0] st_rd_data;
  logic [`RTCYAC_ENTRIES-1:0][7:0] entries;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Address decode of the register map
  always_comb begin
    idx = 3'(({1'b0, req.paddr} - {1'b0, `RTCYAC_OFF_YEAR}) >> 2);
    hit_store = (req.paddr[1:0] == 2'h0) && (req.paddr >= `RTCYAC_OFF_YEAR)
                && (req.paddr <= `RTCYAC_OFF_AYEAR);
    hit_status = (req.paddr == `RTCYAC_OFF_STATUS);
    hit_mask = (req.paddr == `RTCYAC_OFF_MASK);
    commit = req.psel && req.penable && (phase == RTCYAC_ANSWER);
    commit_wr = commit && req.pwrite;
  end

  // Year stepping from the month carry, 99 wraps back to 01
  always_comb begin
    year_cur = entries[`RTCYAC_IDX_YEAR][6:0];
    year_inc = (year_cur == `RTCYAC_YEAR_LAST) ? `RTCYAC_YEAR_FIRST : year_cur + 7'h01;
  end

  // Store write port, a software write wins over a carry in the same cycle
  always_comb begin
    st_wr_en = 1'b0;
    st_wr_idx = `RTCYAC_IDX_YEAR;
    st_wr_data = 8'h00;
    if (commit_wr && hit_store) begin
      st_wr_en = 1'b1;
      st_wr_idx = idx;
      st_wr_data = req.pwdata[7:0];
    end else if (month_carry) begin
      st_wr_en = 1'b1;
      st_wr_data = {1'b0, year_inc};
    end
  end

  // Storage with no reset on its entries
  rtcyac_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .wr_en(st_wr_en),
    .wr_idx(st_wr_idx),
    .wr_data(st_wr_data),
    .rd_idx(idx),
    .rd_data(st_rd_data),
    .entries(entries)
  );

  // Alarm compare of all five fields
  always_comb begin
    match_now = (cur_time.minute == entries[`RTCYAC_IDX_AMIN][5:0])
                && (cur_time.hour == entries[`RTCYAC_IDX_AHOUR][4:0])
                && (cur_time.day == entries[`RTCYAC_IDX_ADAY][4:0])
                && (cur_time.month == entries[`RTCYAC_IDX_AMON][3:0])
                && (year_cur == entries[`RTCYAC_IDX_AYEAR][6:0]);
    events = '0;
    events[`RTCYAC_EV_ALARM] = match_now && !match_q;
    events[`RTCYAC_EV_WRAP] = month_carry && (year_cur == `RTCYAC_YEAR_LAST)
                              && !(commit_wr && hit_store);
    next_match_q = clk_en ? match_now : match_q;
  end

  // Status, mask and interrupt, a new event beats a clear
  always_comb begin
    next_status = status;
    next_mask = mask;
    if (clk_en) begin
      if (commit_wr && hit_status) begin
        next_status = status & ~req.pwdata[`RTCYAC_EV_BITS-1:0];
      end
      if (commit_wr && hit_mask) begin
        next_mask = req.pwdata[`RTCYAC_EV_BITS-1:0];
      end
      next_status = next_status | events;
    end
    next_irq = |(next_status & next_mask);
    next_alarm_flag = next_status[`RTCYAC_EV_ALARM];
    next_year_value = (clk_en && st_wr_en && (st_wr_idx == `RTCYAC_IDX_YEAR))
                      ? st_wr_data[6:0] : year_cur;
  end

  // APB answer: one wait cycle, then pready with data
  always_comb begin
    next_phase = phase;
    next_pready = pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (clk_en) begin
      unique case (phase)
        RTCYAC_IDLE: begin
          if (req.psel && req.penable) begin
            next_phase = RTCYAC_ANSWER;
            next_pready = 1'b1;
            next_pslverr = !(hit_store || hit_status || hit_mask);
            next_prdata = 32'h0000_0000;
            if (!req.pwrite && hit_store) begin
              next_prdata = {24'h00_0000, st_rd_data};
            end else if (!req.pwrite && hit_status) begin
              next_prdata = {30'h0000_0000, status};
            end else if (!req.pwrite && hit_mask) begin
              next_prdata = {30'h0000_0000, mask};
            end
          end
        end
        RTCYAC_ANSWER: begin
          next_phase = RTCYAC_IDLE;
          next_pready = 1'b0;
          next_pslverr = 1'b0;
        end
      endcase
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= RTCYAC_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      status <= `RTCYAC_STATUS_RESET;
      mask <= `RTCYAC_MASK_RESET;
      irq <= 1'b0;
      match_q <= 1'b0;
      alarm_pending_flag <= 1'b0;
    end else begin
      phase <= next_phase;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
      match_q <= next_match_q;
      alarm_pending_flag <= next_alarm_flag;
    end
  end

  // Year output mirror, unreset like the counter itself
  always_ff @(posedge pclk) begin
    year_value <= next_year_value;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A committed software write to one store entry
  sequence s_store_write(logic [2:0] which);
    clk_en && commit_wr && hit_store && (idx == which);
  endsequence

  // A carry stepping the year with no software write competing
  sequence s_carry_step;
    clk_en && month_carry && !(commit_wr && hit_store);
  endsequence

  AST_YEAR_STEP: assert property (
    s_carry_step ##0 (year_cur != `RTCYAC_YEAR_LAST)
    |=> year_cur == 7'($past(year_cur) + 7'h01))
    else $error("Year did not step by one on carry");

  AST_YEAR_WRAP: assert property (
    s_carry_step ##0 (year_cur == `RTCYAC_YEAR_LAST)
    |=> (year_cur == `RTCYAC_YEAR_FIRST) && status[`RTCYAC_EV_WRAP])
    else $error("Year did not wrap from 99 to 01");

  AST_YEAR_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_YEAR)
    |=> entries[`RTCYAC_IDX_YEAR] == {1'b0, $past(req.pwdata[6:0])} ##1 1'b1)
    else $error("Year write not kept as written");

  AST_AMIN_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_AMIN)
    |=> entries[`RTCYAC_IDX_AMIN] == {2'b00, $past(req.pwdata[5:0])})
    else $error("Alarm minute write not kept as written");

  AST_AHOUR_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_AHOUR)
    |=> entries[`RTCYAC_IDX_AHOUR] == {3'b000, $past(req.pwdata[4:0])})
    else $error("Alarm hour write not kept as written");

  AST_ADAY_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_ADAY)
    |=> entries[`RTCYAC_IDX_ADAY] == {3'b000, $past(req.pwdata[4:0])})
    else $error("Alarm day write not kept as written");

  AST_AMON_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_AMON)
    |=> entries[`RTCYAC_IDX_AMON] == {4'h0, $past(req.pwdata[3:0])})
    else $error("Alarm month write not kept as written");

  AST_AYEAR_WRITE: assert property (
    s_store_write(`RTCYAC_IDX_AYEAR)
    |=> entries[`RTCYAC_IDX_AYEAR] == {1'b0, $past(req.pwdata[6:0])})
    else $error("Alarm year write not kept as written");

  AST_ALARM_SET: assert property (
    clk_en && match_now && !match_q |=> alarm_pending_flag && status[`RTCYAC_EV_ALARM])
    else $error("Alarm flag not set on full match");

  AST_FLAG_CLEAR: assert property (
    clk_en && commit_wr && hit_status && req.pwdata[`RTCYAC_EV_ALARM]
    && !events[`RTCYAC_EV_ALARM] |=> !alarm_pending_flag)
    else $error("Writing one did not clear the alarm flag");

  AST_FLAG_ZERO: assert property (
    clk_en && commit_wr && hit_status && !req.pwdata[`RTCYAC_EV_ALARM]
    && alarm_pending_flag |=> alarm_pending_flag)
    else $error("Writing zero disturbed the alarm flag");

  AST_IRQ_LEVEL: assert property (
    irq == |(status & mask))
    else $error("Interrupt output disagrees with status and mask");

  AST_PREADY_ONE: assert property (
    clk_en && psel && penable && (phase == RTCYAC_IDLE) |=> pready ##1 (!pready || !$past(clk_en)))
    else $error("Ready did not answer after one wait cycle");

endmodule : rtcyac_top
`default_nettype wire

// ### dv/rtcyac_top_bench.sv
/*
  Bench for the year counter and alarm compare block: field storage, unmapped
  access, year stepping, alarm flag and interrupt, retention over reset.
  Assumes the design files under hw/ and the configuration header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcyac_cfg.svh"

module rtcyac_top_bench
  import rtcyac_pkg::*;
;
  logic pclk, presetn, clk_en, psel, penable, pwrite, month_carry;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, alarm_pending_flag, er;
  logic [6:0] year_value;
  rtcyac_time_type cur_time, hit;
  int err_total, cmp_count, cycles;

  rtcyac_top u_rtcyac_top (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cur_time(cur_time),
    .month_carry(month_carry),
    .year_value(year_value),
    .alarm_pending_flag(alarm_pending_flag),
    .irq(irq)
  );

  // Clock of 50 ns period
  always #25 pclk = ~pclk;

  // Cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_sim();
    end
  end

  // Compares one result and keeps the tallies
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; an idle edge first keeps drivers single per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("wait", 32'h0000_0002, n);
  endtask : apb

  // Reads a register and compares it
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rchk

  // Writes a value and expects it back within the field
  task automatic store_chk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    apb(1'b1, a, {24'h00_0000, v});
    rchk("store", a, {24'h00_0000, v & m});
  endtask : store_chk

  // Waits a bounded time for the alarm flag to reach a level
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (alarm_pending_flag !== v && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk("flag", {31'h0, v}, {31'h0, alarm_pending_flag});
  endtask : wait_flag

  // Sends one month carry pulse
  task automatic carry();
    @(posedge pclk);
    month_carry <= 1'b1;
    @(posedge pclk);
    month_carry <= 1'b0;
  endtask : carry

  // Prints the counts and the verdict, then stops
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, month_carry} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cur_time = '0;
    hit = '{minute: 6'h1E, hour: 5'h0C, day: 5'h0F, month: 4'h6};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Out-of-range values kept, reserved bits read zero
    store_chk(`RTCYAC_OFF_YEAR, 8'h00, `RTCYAC_MASK_YEAR);
    store_chk(`RTCYAC_OFF_YEAR, 8'hE4, `RTCYAC_MASK_YEAR);
    store_chk(`RTCYAC_OFF_AMIN, 8'h3C, `RTCYAC_MASK_AMIN);
    store_chk(`RTCYAC_OFF_AMIN, 8'hFF, `RTCYAC_MASK_AMIN);
    store_chk(`RTCYAC_OFF_AHOUR, 8'h18, `RTCYAC_MASK_AHOUR);
    store_chk(`RTCYAC_OFF_AHOUR, 8'hFF, `RTCYAC_MASK_AHOUR);
    store_chk(`RTCYAC_OFF_ADAY, 8'h00, `RTCYAC_MASK_ADAY);
    store_chk(`RTCYAC_OFF_ADAY, 8'hFF, `RTCYAC_MASK_ADAY);
    store_chk(`RTCYAC_OFF_AMON, 8'h00, `RTCYAC_MASK_AMON);
    store_chk(`RTCYAC_OFF_AMON, 8'hFD, `RTCYAC_MASK_AMON);
    store_chk(`RTCYAC_OFF_AYEAR, 8'h00, `RTCYAC_MASK_AYEAR);
    store_chk(`RTCYAC_OFF_AYEAR, 8'hE4, `RTCYAC_MASK_AYEAR);
    // Unmapped places answer with an error and change nothing
    apb(1'b1, 8'h40, 32'h0000_0011);
    chk("wr err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("rd err", 32'h1, {31'h0, er});
    chk("rd data", 32'h0, rd);
    rchk("year kept", `RTCYAC_OFF_YEAR, 32'h0000_0064);
    // Alarm on a full match of all five fields
    apb(1'b1, `RTCYAC_OFF_YEAR, 32'h0000_0020);
    apb(1'b1, `RTCYAC_OFF_AMIN, 32'h0000_001E);
    apb(1'b1, `RTCYAC_OFF_AHOUR, 32'h0000_000C);
    apb(1'b1, `RTCYAC_OFF_ADAY, 32'h0000_000F);
    apb(1'b1, `RTCYAC_OFF_AMON, 32'h0000_0006);
    apb(1'b1, `RTCYAC_OFF_AYEAR, 32'h0000_0020);
    apb(1'b1, `RTCYAC_OFF_STATUS, 32'h0000_0003);
    apb(1'b1, `RTCYAC_OFF_MASK, 32'h0000_0001);
    wait_flag(1'b0);
    cur_time <= hit;
    wait_flag(1'b1);
    rchk("status", `RTCYAC_OFF_STATUS, 32'h0000_0001);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, `RTCYAC_OFF_STATUS, 32'h0000_0000);
    wait_flag(1'b1);
    apb(1'b1, `RTCYAC_OFF_STATUS, 32'h0000_0001);
    wait_flag(1'b0);
    rchk("status clr", `RTCYAC_OFF_STATUS, 32'h0000_0000);
    chk("irq off", 32'h0, {31'h0, irq});
    // Masked alarm still flags but keeps the interrupt low
    apb(1'b1, `RTCYAC_OFF_MASK, 32'h0000_0000);
    cur_time <= '0;
    repeat (3) @(posedge pclk);
    cur_time <= hit;
    wait_flag(1'b1);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `RTCYAC_OFF_STATUS, 32'h0000_0003);
    // Year steps on carry and 99 wraps to 01; only real years are written
    apb(1'b1, `RTCYAC_OFF_YEAR, 32'h0000_0063);
    carry();
    rchk("wrap", `RTCYAC_OFF_YEAR, 32'h0000_0001);
    chk("mirror", 32'h1, {25'h0, year_value});
    rchk("wrap ev", `RTCYAC_OFF_STATUS, 32'h0000_0002);
    apb(1'b1, `RTCYAC_OFF_YEAR, 32'h0000_0030);
    carry();
    rchk("step", `RTCYAC_OFF_YEAR, 32'h0000_0031);
    // A carry while the clock enable is low leaves the year alone
    clk_en <= 1'b0;
    carry();
    clk_en <= 1'b1;
    rchk("frozen", `RTCYAC_OFF_YEAR, 32'h0000_0031);
    chk("mirror frozen", 32'h0000_0031, {25'h0, year_value});
    // Second reset leaves the year and compare values alone
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("year rst", `RTCYAC_OFF_YEAR, 32'h0000_0031);
    chk("mirror rst", 32'h0000_0031, {25'h0, year_value});
    rchk("amin rst", `RTCYAC_OFF_AMIN, 32'h0000_001E);
    rchk("ayear rst", `RTCYAC_OFF_AYEAR, 32'h0000_0020);
    rchk("status rst", `RTCYAC_OFF_STATUS, 32'h0000_0000);
    rchk("mask rst", `RTCYAC_OFF_MASK, 32'h0000_0000);
    end_sim();
  end
endmodule : rtcyac_top_bench
`default_nettype wire
